// ### adpm_pkg.sv
// Purpose: constants for the audio dac pin mode and reset block
// Assumes: 200 MHz system clock, register port with one-cycle read latency
// Notes:   shared by the design and by the bench
// Function
// - func_choice low: audio data on serial out; high: coded audio instead
// - pin a: next-track key when choice high, frame clock output when low
// - pin b: previous-track key when choice high, bit clock output when low
// - pin c: stop key when choice high, system clock output when low
// - pin d: play/pause key or serial audio data in; always an input
// - mute key on rom variant, programming select on serial variant
// - volume-up key on rom variant, programming clock on serial variant
// - volume-down key on rom variant, programming data on serial variant
// - self-powered: attach pin tracks host supply for attach and detach
// - bus-powered: attach pin low means 100 mA, high means 500 mA
// - power source choice low means self-powered, high means bus-powered
// - suspend flag low while suspended, high while operational
// - rom variant drives rom clock; serial variant leaves it unused
// - rom data line two-way on rom variant; only pulled up otherwise
// - suspend flag never gates or stops the clock
// - internal reset releases about 700 us after supply is good
package adpm_pkg;
  // register map
  localparam int         ADDR_W      = 8;
  localparam int         DATA_W      = 32;
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] SAMPLE_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] RX_OFS      = 8'h0C;
  // control fields
  localparam int         CTRL_W      = 4;
  localparam int         CTRL_SUSP   = 0;
  localparam int         CTRL_RCLK   = 1;
  localparam int         CTRL_RDAT   = 2;
  localparam int         CTRL_ROE    = 3;
  localparam logic [3:0] CTRL_RST    = 4'h0;
  localparam logic [31:0] SAMPLE_RST = 32'h0;
  // synchroniser lanes
  localparam int SYNC_W = 13;
  localparam int S_FUNC = 0;
  localparam int S_PA   = 1;
  localparam int S_PB   = 2;
  localparam int S_PC   = 3;
  localparam int S_PD   = 4;
  localparam int S_MUTE = 5;
  localparam int S_VUP  = 6;
  localparam int S_VDN  = 7;
  localparam int S_HOST = 8;
  localparam int S_PSEL = 9;
  localparam int S_TEST = 10;
  localparam int S_ROMD = 11;
  localparam int S_VAR  = 12;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int POR_TIME_NS   = 700000;
  localparam int POR_CYCLES    =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          POR_W      = 18;
  localparam logic [3:0]  SYS_HALF   = 4'h8;
  localparam logic [5:0]  BIT_HALF   = 6'h20;
  localparam int          FRAME_BITS = 32;
  // reset sequencer
  typedef enum logic [1:0] {
    ADPM_HOLD = 2'b01,
    ADPM_RUN  = 2'b10
  } adpm_por_t;
endpackage

// ### adpm_top.sv
// Purpose: pin function select, power selects, suspend flag, reset release
// Assumes: pins arrive asynchronous; register port on clock_i
// Notes:   audio clocks come from clock_i dividers and never stop
module adpm_top #(
  parameter int POR_CYCLES = adpm_pkg::POR_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        func_choice_i,
  input  wire logic        rom_variant_i,
  input  wire logic        multi_pin_a_i,
  output logic             multi_pin_a_o,
  output logic             multi_pin_a_oe_o,
  input  wire logic        multi_pin_b_i,
  output logic             multi_pin_b_o,
  output logic             multi_pin_b_oe_o,
  input  wire logic        multi_pin_c_i,
  output logic             multi_pin_c_o,
  output logic             multi_pin_c_oe_o,
  input  wire logic        multi_pin_d_i,
  input  wire logic        key_mute_in_i,
  input  wire logic        key_vol_up_in_i,
  input  wire logic        key_vol_down_in_i,
  input  wire logic        attach_or_power_sel_i,
  input  wire logic        power_source_choice_i,
  input  wire logic        test_i,
  input  wire logic        rom_serial_data_i,
  output logic             rom_serial_data_o,
  output logic             rom_serial_data_oe_o,
  output logic             rom_serial_clk_o,
  output logic             serial_audio_out_o,
  output logic             suspend_flag_n_o,
  output logic      [3:0]  media_keys_o,
  output logic      [2:0]  hid_keys_o,
  output logic             prog_select_o,
  output logic             prog_serial_clk_o,
  output logic             prog_serial_data_o,
  output logic             bus_powered_o,
  output logic             current_500ma_o,
  output logic             host_attached_o,
  output logic             attach_event_o,
  output logic             detach_event_o,
  output logic             ready_o
);
  logic [12:0] sync1_reg, sync2_reg, s;
  logic        run, func_s, var_reg, host_reg;
  logic [17:0] por_cnt_reg;
  adpm_pkg::adpm_por_t por_reg;
  logic [3:0]  ctrl_reg;
  logic [31:0] sample_reg, tx_reg, rx_reg, rx_word_reg;
  logic [3:0]  sys_cnt_reg;
  logic [5:0]  div_reg;
  logic [4:0]  bit_cnt_reg;
  logic        sck_reg, bck_reg, bmc_reg, bck_fall, bck_rise;

  // register address match, used by both write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= 13'h0;
      sync2_reg <= 13'h0;
    end else begin
      sync1_reg <= {rom_variant_i, rom_serial_data_i, test_i,
                    power_source_choice_i, attach_or_power_sel_i,
                    key_vol_down_in_i, key_vol_up_in_i, key_mute_in_i,
                    multi_pin_d_i, multi_pin_c_i, multi_pin_b_i,
                    multi_pin_a_i, func_choice_i};
      sync2_reg <= sync1_reg;
    end
  end
  assign s      = sync2_reg;
  assign func_s = s[adpm_pkg::S_FUNC];

  // internal reset release: hold until the supply has settled
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      por_reg     <= adpm_pkg::ADPM_HOLD;
      por_cnt_reg <= 18'h0;
    end else begin
      unique case (por_reg)
        adpm_pkg::ADPM_HOLD: begin
          if (por_cnt_reg == 18'(POR_CYCLES - 1)) begin
            por_reg <= adpm_pkg::ADPM_RUN;
          end else begin
            por_cnt_reg <= por_cnt_reg + 18'h1;
          end
        end
        adpm_pkg::ADPM_RUN: begin
          por_reg <= adpm_pkg::ADPM_RUN;
        end
        default: begin
          por_reg <= adpm_pkg::ADPM_HOLD;
        end
      endcase
    end
  end
  assign run     = (por_reg == adpm_pkg::ADPM_RUN);
  assign ready_o = run;

  // variant strap sampled every cycle while held in internal reset, kept from release on
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      var_reg <= 1'b1;
    end else if (!run) begin
      var_reg <= s[adpm_pkg::S_VAR];
    end
  end

  // software registers; writes ignored until reset release
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg   <= adpm_pkg::CTRL_RST;
      sample_reg <= adpm_pkg::SAMPLE_RST;
    end else if (wr_i && run) begin
      if (hit(addr_i, adpm_pkg::CTRL_OFS)) begin
        ctrl_reg <= wdata_i[3:0];
      end
      if (hit(addr_i, adpm_pkg::SAMPLE_OFS)) begin
        sample_reg <= wdata_i;
      end
    end
  end

  // read data stand one cycle only; unmapped reads give zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0;
    end else if (!rd_i) begin
      rdata_o <= 32'h0;
    end else if (hit(addr_i, adpm_pkg::CTRL_OFS)) begin
      rdata_o <= {28'h0, ctrl_reg};
    end else if (hit(addr_i, adpm_pkg::SAMPLE_OFS)) begin
      rdata_o <= sample_reg;
    end else if (hit(addr_i, adpm_pkg::STATUS_OFS)) begin
      rdata_o <= {14'h0, prog_serial_data_o, prog_serial_clk_o,
                  prog_select_o, hid_keys_o, media_keys_o,
                  s[adpm_pkg::S_ROMD], ~suspend_flag_n_o,
                  s[adpm_pkg::S_TEST], var_reg, host_attached_o,
                  current_500ma_o, bus_powered_o, func_s};
    end else if (hit(addr_i, adpm_pkg::RX_OFS)) begin
      rdata_o <= rx_word_reg;
    end else begin
      rdata_o <= 32'h0;
    end
  end

  // audio clock dividers run free, suspend never stops them
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_cnt_reg <= 4'h0;
      sck_reg     <= 1'b0;
    end else if (sys_cnt_reg == adpm_pkg::SYS_HALF - 4'h1) begin
      sys_cnt_reg <= 4'h0;
      sck_reg     <= ~sck_reg;
    end else begin
      sys_cnt_reg <= sys_cnt_reg + 4'h1;
    end
  end

  assign bck_fall = (div_reg == adpm_pkg::BIT_HALF - 6'h1) && bck_reg;
  assign bck_rise = (div_reg == adpm_pkg::BIT_HALF - 6'h1) && !bck_reg;

  // bit clock and frame position; frame clock is the top count bit
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg     <= 6'h0;
      bck_reg     <= 1'b0;
      bit_cnt_reg <= 5'h0;
    end else if (div_reg == adpm_pkg::BIT_HALF - 6'h1) begin
      div_reg <= 6'h0;
      bck_reg <= ~bck_reg;
      if (bck_reg) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h1;
      end
    end else begin
      div_reg <= div_reg + 6'h1;
    end
  end

  // transmit shifter: msb first, new word at frame start
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_reg <= 32'h0;
    end else if (bck_fall) begin
      if (bit_cnt_reg == 5'(adpm_pkg::FRAME_BITS - 1)) begin
        tx_reg <= sample_reg;
      end else begin
        tx_reg <= {tx_reg[30:0], 1'b0};
      end
    end
  end

  // biphase mark coding: edge at every cell start, mid-cell edge for a one
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bmc_reg <= 1'b0;
    end else if (bck_fall || (bck_rise && tx_reg[31])) begin
      bmc_reg <= ~bmc_reg;
    end
  end

  // receive shifter on bit clock rise; word kept at frame end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_reg      <= 32'h0;
      rx_word_reg <= 32'h0;
    end else if (bck_rise && run && !func_s) begin
      rx_reg <= {rx_reg[30:0], s[adpm_pkg::S_PD]};
      if (bit_cnt_reg == 5'(adpm_pkg::FRAME_BITS - 1)) begin
        rx_word_reg <= {rx_reg[30:0], s[adpm_pkg::S_PD]};
      end
    end
  end

  // shared pins: clock outputs when choice low, keys read when high
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      multi_pin_a_o      <= 1'b0;
      multi_pin_b_o      <= 1'b0;
      multi_pin_c_o      <= 1'b0;
      multi_pin_a_oe_o   <= 1'b0;
      multi_pin_b_oe_o   <= 1'b0;
      multi_pin_c_oe_o   <= 1'b0;
      serial_audio_out_o <= 1'b0;
      media_keys_o       <= 4'h0;
    end else begin
      multi_pin_a_o      <= bit_cnt_reg[4];
      multi_pin_b_o      <= bck_reg;
      multi_pin_c_o      <= sck_reg;
      multi_pin_a_oe_o   <= run && !func_s;
      multi_pin_b_oe_o   <= run && !func_s;
      multi_pin_c_oe_o   <= run && !func_s;
      serial_audio_out_o <= run && (func_s ? bmc_reg : tx_reg[31]);
      media_keys_o       <= (run && func_s) ?
                            s[adpm_pkg::S_PD:adpm_pkg::S_PA] : 4'h0;
    end
  end

  // variant-shared key pins and power selects
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hid_keys_o         <= 3'h0;
      prog_select_o      <= 1'b0;
      prog_serial_clk_o  <= 1'b0;
      prog_serial_data_o <= 1'b0;
      bus_powered_o      <= 1'b0;
      current_500ma_o    <= 1'b0;
      host_attached_o    <= 1'b0;
    end else begin
      hid_keys_o <= (run && var_reg) ?
                    s[adpm_pkg::S_VDN:adpm_pkg::S_MUTE] : 3'h0;
      prog_select_o      <= run && !var_reg && s[adpm_pkg::S_MUTE];
      prog_serial_clk_o  <= run && !var_reg && s[adpm_pkg::S_VUP];
      prog_serial_data_o <= run && !var_reg && s[adpm_pkg::S_VDN];
      bus_powered_o      <= run && s[adpm_pkg::S_PSEL];
      current_500ma_o    <= run && s[adpm_pkg::S_PSEL]
                            && s[adpm_pkg::S_HOST];
      host_attached_o    <= run && !s[adpm_pkg::S_PSEL]
                            && s[adpm_pkg::S_HOST];
    end
  end

  // attach and detach pulses from host supply edges, self-powered only
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_reg       <= 1'b0;
      attach_event_o <= 1'b0;
      detach_event_o <= 1'b0;
    end else begin
      host_reg       <= host_attached_o;
      attach_event_o <= host_attached_o && !host_reg;
      detach_event_o <= !host_attached_o && host_reg;
    end
  end

  // suspend flag and rom pins; serial variant never drives the rom side
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      suspend_flag_n_o     <= 1'b1;
      rom_serial_clk_o     <= 1'b0;
      rom_serial_data_o    <= 1'b0;
      rom_serial_data_oe_o <= 1'b0;
    end else begin
      suspend_flag_n_o  <= !ctrl_reg[adpm_pkg::CTRL_SUSP];
      rom_serial_clk_o  <= var_reg && ctrl_reg[adpm_pkg::CTRL_RCLK];
      rom_serial_data_o <= var_reg && ctrl_reg[adpm_pkg::CTRL_RDAT];
      rom_serial_data_oe_o <= var_reg
                              && ctrl_reg[adpm_pkg::CTRL_ROE];
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence por_end_s;
    !run ##1 run;
  endsequence

  por_release_a: assert property (
    por_end_s |-> $past(por_cnt_reg) == 18'(POR_CYCLES - 1))
    else $error("reset released at wrong count");
  pin_dir_a: assert property (
    $past(run) && !$past(func_s) |-> multi_pin_a_oe_o && multi_pin_b_oe_o
      && multi_pin_c_oe_o)
    else $error("shared pin not driven in serial mode");
  key_mode_a: assert property (
    $past(func_s) |-> !multi_pin_a_oe_o && !multi_pin_b_oe_o
      && !multi_pin_c_oe_o)
    else $error("shared pin driven in key mode");
  frame_clk_a: assert property (
    $rose(bit_cnt_reg[4]) |-> ##1 multi_pin_a_o ##0 $past(bck_reg, 2))
    else $error("frame clock not aligned to bit clock");
  bmc_cell_a: assert property (
    bck_fall |=> bmc_reg != $past(bmc_reg))
    else $error("coded output lost cell edge");
  play_key_a: assert property (
    run && func_s && $stable(func_s) |=> media_keys_o[3] == $past(
      s[adpm_pkg::S_PD]))
    else $error("play key not passed");
  prog_var_a: assert property (
    var_reg |=> !prog_select_o && !prog_serial_clk_o && !prog_serial_data_o)
    else $error("programming pins active on rom variant");
  rom_quiet_a: assert property (
    !var_reg |=> !rom_serial_data_oe_o && !rom_serial_clk_o)
    else $error("rom pins driven on serial variant");
  current_a: assert property (
    run && s[adpm_pkg::S_PSEL] && !s[adpm_pkg::S_HOST] |=> !current_500ma_o)
    else $error("wrong current selection");
  suspend_a: assert property (
    ctrl_reg[adpm_pkg::CTRL_SUSP] |=> !suspend_flag_n_o)
    else $error("suspend flag not low in suspend");
  sync_pipe_a: assert property (
    run |-> sync2_reg == $past(sync1_reg))
    else $error("synchroniser stage skipped");
endmodule

// ### adpm_far_side.sv
// Purpose: far side of the pins: key pads, serial audio source, rom line
// Assumes: watches the design's pad outputs on the system clock
// Notes:   the source word repeats every frame, most significant bit first
module adpm_far_side #(
  parameter logic [31:0] WORD = 32'hC3A5_0F96
) (
  input  wire logic       clock_i,
  input  wire logic [3:0] keys_i,
  input  wire logic [2:0] drv_i,
  input  wire logic [2:0] oe_i,
  input  wire logic       rom_d_i,
  input  wire logic       rom_oe_i,
  output logic      [3:0] pins_o,
  output logic            rom_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        bclk_q  = 1'b0;
  logic        frame_q = 1'b0;
  logic        sdat    = 1'b0;
  logic [31:0] shift_q = 32'h0;
  // released pads show the key level, pad d the source data while pad b is driven; an idle key sits on its pulldown
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      pins_o[k] = oe_i[k] ? drv_i[k] : keys_i[k];
    end
    pins_o[3] = oe_i[1] ? sdat : keys_i[3];
    rom_wire_o = rom_oe_i ? rom_d_i : 1'b1; // pull-up only
  end
  // sample on the system clock so the two pad clocks never race
  always @(posedge clock_i) begin
    bclk_q <= pins_o[1];
    if (bclk_q && !pins_o[1]) begin
      frame_q <= pins_o[0];
      if (frame_q && !pins_o[0]) begin
        sdat    <= WORD[31];
        shift_q <= {WORD[30:0], 1'b0};
      end else begin
        sdat    <= shift_q[31];
        shift_q <= {shift_q[30:0], 1'b0};
      end
    end
  end
endmodule

// ### testbench.sv
// Purpose: self-checking bench for the pin mode and reset block
// Assumes: reset count shortened to 20 cycles
// Notes:   key, rom, power, suspend and serial audio paths in turn
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          POR = 20;
  localparam logic [31:0] RXW = 32'hC3A5_0F96;
  localparam int          BITP = 2 * int'(adpm_pkg::BIT_HALF);
  localparam int          FRP  = adpm_pkg::FRAME_BITS * BITP;
  logic        clock_i = 1'b0;
  logic        rstn_i, wr_i, rd_i, func_choice_i, rom_variant_i;
  logic        attach_or_power_sel_i, power_source_choice_i, test_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, got;
  logic [3:0]  keys, pins, media_keys_o;
  logic [2:0]  hid_in, hid_keys_o, drv, oe;
  logic        rom_wire, rom_d, rom_oe, rom_serial_clk_o, serial_audio_out_o;
  logic        suspend_flag_n_o, prog_select_o, prog_serial_clk_o;
  logic        prog_serial_data_o, bus_powered_o, current_500ma_o;
  logic        host_attached_o, attach_event_o, detach_event_o, ready_o;
  int          miscompares = 0;
  int          n_tests = 0;

  // one system clock stands in for the single accurate source
  always #2.5 clock_i = ~clock_i; // driven in, nothing on the out pad

  adpm_top #(.POR_CYCLES(POR)) adpm_top_i (
    .clock_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .func_choice_i, .rom_variant_i,
    .multi_pin_a_i(pins[0]), .multi_pin_a_o(drv[0]), .multi_pin_a_oe_o(oe[0]),
    .multi_pin_b_i(pins[1]), .multi_pin_b_o(drv[1]), .multi_pin_b_oe_o(oe[1]),
    .multi_pin_c_i(pins[2]), .multi_pin_c_o(drv[2]), .multi_pin_c_oe_o(oe[2]),
    .multi_pin_d_i(pins[3]), .key_mute_in_i(hid_in[0]),
    .key_vol_up_in_i(hid_in[1]), .key_vol_down_in_i(hid_in[2]),
    .attach_or_power_sel_i, .power_source_choice_i, .test_i,
    .rom_serial_data_i(rom_wire), .rom_serial_data_o(rom_d),
    .rom_serial_data_oe_o(rom_oe), .rom_serial_clk_o, .serial_audio_out_o,
    .suspend_flag_n_o, .media_keys_o, .hid_keys_o, .prog_select_o,
    .prog_serial_clk_o, .prog_serial_data_o, .bus_powered_o,
    .current_500ma_o, .host_attached_o, .attach_event_o, .detach_event_o,
    .ready_o);

  adpm_far_side #(.WORD(RXW)) adpm_far_side_i (.clock_i, .keys_i(keys),
    .drv_i(drv), .oe_i(oe), .rom_d_i(rom_d), .rom_oe_i(rom_oe),
    .pins_o(pins), .rom_wire_o(rom_wire));

  task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic bus_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic bus_rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // cycles until the next rising edge of one pad
  task automatic rise(int s, output int n);
    logic prv;
    n = 0;
    do begin
      prv = pins[s];
      cyc(1);
      n++;
    end while (!(pins[s] === 1'b1 && prv === 1'b0) && n < 5000);
  endtask
  task automatic period(int s, int exp_p, string what);
    int n;
    rise(s, n);
    rise(s, n);
    chk(what, 32'(exp_p), 32'(n));
  endtask
  task automatic ones(output int n);
    n = 0;
    repeat (FRP) begin
      cyc(1);
      if (serial_audio_out_o === 1'b1) n++;
    end
  endtask
  task automatic do_reset(logic rom);
    @(posedge clock_i);
    rstn_i        <= 1'b0;
    rom_variant_i <= rom;
    cyc(5);
    chk("flag in reset", 32'h1, 32'(suspend_flag_n_o));
    chk("ready in reset", 32'h0, 32'(ready_o));
    @(posedge clock_i);
    rstn_i <= 1'b1;
    // a write during the hold must be dropped
    bus_wr(adpm_pkg::CTRL_OFS, 32'h1);
    repeat (POR - 3) @(posedge clock_i);
    #1 chk("ready early", 32'h0, 32'(ready_o));
    cyc(1);
    chk("ready on time", 32'h1, 32'(ready_o));
    chk("early write", 32'h1, 32'(suspend_flag_n_o));
  endtask
  task automatic t_keys;
    @(posedge clock_i);
    func_choice_i <= 1'b1;
    keys          <= 4'hA;
    hid_in        <= 3'h5;
    cyc(5);
    chk("pad enables", 32'h0, 32'(oe));
    chk("media keys", 32'hA, 32'(media_keys_o));
    chk("hid keys", 32'h5, 32'(hid_keys_o));
    @(posedge clock_i);
    keys <= 4'h5;
    cyc(2);
    chk("keys before sync", 32'hA, 32'(media_keys_o));
    cyc(1);
    chk("keys after sync", 32'h5, 32'(media_keys_o));
    bus_rd(adpm_pkg::STATUS_OFS, got);
    chk("status keys", 32'h5, 32'(got[11:8]));
    chk("status mode", 32'h31, got & 32'h31);
  endtask
  task automatic t_rom;
    bus_wr(adpm_pkg::CTRL_OFS, 32'hFFFF_FFFA);
    bus_rd(adpm_pkg::CTRL_OFS, got);
    chk("control readback", 32'hA, got);
    chk("rom clock", 32'h1, 32'(rom_serial_clk_o));
    chk("rom drive", 32'h2, {30'h0, rom_oe, rom_d});
    cyc(3);
    bus_rd(adpm_pkg::STATUS_OFS, got);
    chk("rom line low", 32'h0, 32'(got[7]));
    bus_wr(adpm_pkg::CTRL_OFS, 32'h0);
    cyc(4);
    bus_rd(adpm_pkg::STATUS_OFS, got);
    chk("rom line pulled", 32'h1, 32'(got[7]));
    bus_rd(8'h10, got);
    chk("unmapped read", 32'h0, got);
  endtask
  task automatic t_power;
    int na;
    int nd;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      power_source_choice_i <= i[1];
      attach_or_power_sel_i <= i[0];
      cyc(4);
      chk("bus powered", 32'(i[1]), 32'(bus_powered_o));
      if (i[1]) begin
        chk("500 mA", 32'(i[0]), 32'(current_500ma_o));
      end else begin
        chk("host seen", 32'(i[0]), 32'(host_attached_o));
      end
    end
    // host supply low first, so the attach pulse comes from the pin itself
    @(posedge clock_i);
    power_source_choice_i <= 1'b0;
    attach_or_power_sel_i <= 1'b0;
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge clock_i);
      attach_or_power_sel_i <= (ph == 0);
      na = 0;
      nd = 0;
      repeat (8) begin
        cyc(1);
        if (attach_event_o === 1'b1) na++;
        if (detach_event_o === 1'b1) nd++;
      end
      chk("attach pulses", 32'(ph == 0), 32'(na));
      chk("detach pulses", 32'(ph == 1), 32'(nd));
    end
  endtask
  task automatic t_serial;
    int n;
    @(posedge clock_i);
    func_choice_i <= 1'b0;
    keys          <= 4'hF;
    cyc(5);
    chk("pads driven", 32'h7, 32'(oe));
    chk("keys masked", 32'h0, 32'(media_keys_o));
    period(0, FRP, "frame clock");
    period(1, BITP, "bit clock");
    period(2, 2 * int'(adpm_pkg::SYS_HALF), "system clock");
    // suspend must not stop the audio clocks
    bus_wr(adpm_pkg::CTRL_OFS, 32'h1);
    cyc(2);
    chk("suspended flag", 32'h0, 32'(suspend_flag_n_o));
    period(1, BITP, "clock in suspend");
    bus_wr(adpm_pkg::CTRL_OFS, 32'h0);
    cyc(2);
    chk("awake flag", 32'h1, 32'(suspend_flag_n_o));
    cyc(2 * FRP);
    bus_rd(adpm_pkg::RX_OFS, got);
    chk("data in word", RXW, got);
    bus_wr(adpm_pkg::SAMPLE_OFS, 32'hFFFF_FFFF);
    cyc(2 * FRP + 100);
    ones(n);
    chk("plain ones", 32'(FRP), 32'(n));
    bus_wr(adpm_pkg::SAMPLE_OFS, 32'h0);
    cyc(2 * FRP + 100);
    ones(n);
    chk("plain zeros", 32'h0, 32'(n));
    @(posedge clock_i);
    func_choice_i <= 1'b1;
    cyc(2 * FRP);
    ones(n);
    chk("coded toggles", 32'h1, 32'(n > 0 && n < FRP));
  endtask
  task automatic t_prog;
    for (int v = 2; v < 6; v += 3) begin
      @(posedge clock_i);
      hid_in <= v[2:0];
      cyc(5);
      chk("prog select", 32'(v[0]), 32'(prog_select_o));
      chk("prog clock", 32'(v[1]), 32'(prog_serial_clk_o));
      chk("prog data", 32'(v[2]), 32'(prog_serial_data_o));
      chk("hid quiet", 32'h0, 32'(hid_keys_o));
    end
    bus_wr(adpm_pkg::CTRL_OFS, 32'h2);
    cyc(2);
    chk("rom clock idle", 32'h0, 32'(rom_serial_clk_o));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rstn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h0;
    wdata_i = 32'h0;
    func_choice_i = 1'b1;
    rom_variant_i = 1'b1;
    attach_or_power_sel_i = 1'b0;
    power_source_choice_i = 1'b0;
    test_i = 1'b1; // held high throughout
    keys = 4'h0;
    hid_in = 3'h0;
    do_reset(1'b1);
    t_keys;
    t_rom;
    t_power;
    t_serial;
    do_reset(1'b0);
    t_prog;
    tally_and_finish;
  end
  // run needs about 30k cycles; cut off well beyond that
  initial begin
    #400000;
    miscompares++;
    tally_and_finish;
  end
endmodule
